// *** design/wpb_pkg.sv ***
package wpb_pkg;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;

	// Control field positions
	localparam int CTRL_LEGACY_WAKE_EN = 0;
	localparam int CTRL_ACPI_MODE = 1;
	localparam int CTRL_SLEEP_BUTTON = 2;
	localparam int CTRL_EMP_ON_B = 3;
	localparam int CTRL_RTC_S1_EN = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Wake source indices
	localparam int NUM_SRC = 8;
	localparam int SRC_BUTTON = 0;
	localparam int SRC_RI_FIRST = 1;
	localparam int SRC_RI_SECOND = 2;
	localparam int SRC_PME = 3;
	localparam int SRC_RTC = 4;
	localparam int SRC_MOUSE = 5;
	localparam int SRC_KBD = 6;
	localparam int SRC_USB = 7;

	// Interrupt status bits
	localparam int NUM_IRQ = 4;
	localparam int IRQ_WAKE = 0;
	localparam int IRQ_BUTTON = 1;
	localparam int IRQ_FORCED_OFF = 2;
	localparam int IRQ_ON = 3;

	// Chipset sleep-state codes
	localparam logic [1:0] SLP_S0 = 2'h0;
	localparam logic [1:0] SLP_S1 = 2'h1;
	localparam logic [1:0] SLP_S4 = 2'h2;
	localparam logic [1:0] SLP_S5 = 2'h3;

	// Timing
	localparam int CLK_MHZ = 125;
	localparam int PWRGD_DELAY_US = 100;
	localparam int PWRGD_CYCLES = PWRGD_DELAY_US * CLK_MHZ;
	localparam int RESET_HOLD_US = 10;
	localparam int RESET_CYCLES = RESET_HOLD_US * CLK_MHZ;
	localparam longint FORCE_OFF_MS = 4000;
	localparam longint FORCE_OFF_CYCLES = FORCE_OFF_MS * 1000 * CLK_MHZ;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_SUPPLY_UP,
		ST_RESET,
		ST_ON,
		ST_SLEEP
	} wpb_state_t;

endpackage

// *** design/wpb_evt_if.sv ***
`timescale 1ns/100ps
interface wpb_evt_if;
	logic [wpb_pkg::NUM_SRC-1:0] raw;
	logic [wpb_pkg::NUM_SRC-1:0] level;
	logic [wpb_pkg::NUM_SRC-1:0] edge_evt;
	modport det (input raw, output level, output edge_evt);
	modport use_side (output raw, input level, input edge_evt);
endinterface

// *** design/wpb_edge_sync.sv ***
`timescale 1ns/100ps
module wpb_edge_sync
	import wpb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	wpb_evt_if.det evt
);

	logic [NUM_SRC-1:0] meta_q;
	logic [NUM_SRC-1:0] sync_q;
	logic [NUM_SRC-1:0] last_q;

	// Two flops per input, then one more stage for the edge compare
	genvar g;
	for (g = 0; g < NUM_SRC; g++) begin : g_src
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				meta_q[g] <= 1'b0;
				sync_q[g] <= 1'b0;
				last_q[g] <= 1'b0;
			end else begin
				meta_q[g] <= evt.raw[g];
				sync_q[g] <= meta_q[g];
				last_q[g] <= sync_q[g];
			end
		end
		assign evt.edge_evt[g] = sync_q[g] & ~last_q[g];
	end
	assign evt.level = sync_q;

endmodule

// *** design/wpb_sequencer.sv ***
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
// What this block does
// - Legacy wake is disabled after reset until software enables it.
// - One control bit enables all legacy wake sources together.
// - Button or chipset wake edge while off starts power-up by hardware.
// - First port ring and PCI PME wake from S1 and S4, legacy too.
// - Second port ring wakes S1/S4 unless that port serves management.
// - RTC alarm wakes S1 if enabled, always from S4, legacy too.
// - Button while on or sleeping only forwarded to chipset, never switches supply directly.
// - Power-up gives power good, then reset release, then on.
// - Legacy mode: button press while on raises SMI.
// - Chipset off state drops the supply-on request.
// - Unserviced legacy button SMI forces power off after 4 seconds.
// - ACPI power button press raises SCI, no direct power removal.
// - ACPI sleep button while on raises SCI for sleep entry.
// - Sleep button while sleeping sends chipset wake and SCI.
module wpb_sequencer
	import wpb_pkg::*;
#(
	parameter longint FORCE_OFF_CYC = FORCE_OFF_CYCLES,
	parameter int PWRGD_CYC = PWRGD_CYCLES,
	parameter int RESET_CYC = RESET_CYCLES
)(
	input wire logic SYS_CLK_I,
	input wire logic RST_N_I,
	input wire logic PWR_BUTTON_N_I,
	input wire logic CHIPSET_WAKE_I,
	input wire logic RI_FIRST_SERIAL_PORT_I,
	input wire logic RI_SECOND_SERIAL_PORT_I,
	input wire logic PCI_PME_I,
	input wire logic RTC_ALARM_I,
	input wire logic MOUSE_WAKE_I,
	input wire logic KBD_WAKE_I,
	input wire logic USB_WAKE_I,
	input wire logic [1:0] SLP_STATE_I,
	output logic SUPPLY_ON_REQUEST_O,
	output logic PWR_GOOD_O,
	output logic SYS_RESET_N_O,
	output logic BUTTON_REQ_O,
	output logic CHIPSET_WAKE_O,
	output logic SMI_O,
	output logic SCI_O,
	output logic IRQ_O,
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);

	wpb_evt_if evt ();
	wpb_state_t state_q;
	logic [31:0] ctrl_q;
	logic [NUM_IRQ-1:0] irq_stat_q;
	logic [NUM_IRQ-1:0] irq_mask_q;
	logic [1:0] slp_meta_q;
	logic [1:0] slp_q;
	logic [1:0] slp_sync_q;
	logic [1:0] slp_prev_q;
	logic [31:0] cnt_q;
	logic [39:0] off_cnt_q;
	logic off_armed_q;
	logic smi_q;
	logic sci_q;
	logic wake_out_q;
	logic btn_req_q;
	logic supply_q;
	logic pwr_good_q;
	logic sys_reset_n_q;
	logic [NUM_IRQ-1:0] irq_set;
	logic [NUM_IRQ-1:0] irq_clr;
	logic btn_evt;
	logic wake_hit;
	logic chipset_off;
	logic force_off;
	logic legacy;

	assign evt.raw = {USB_WAKE_I, KBD_WAKE_I, MOUSE_WAKE_I, RTC_ALARM_I, PCI_PME_I,
		RI_SECOND_SERIAL_PORT_I, RI_FIRST_SERIAL_PORT_I, ~PWR_BUTTON_N_I};

	wpb_edge_sync u_sync (
		.clk_i(SYS_CLK_I),
		.rst_n_i(RST_N_I),
		.evt(evt)
	);

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			slp_meta_q <= SLP_S5;
			slp_sync_q <= SLP_S5;
			slp_prev_q <= SLP_S5;
			slp_q <= SLP_S5;
		end else begin
			slp_meta_q <= SLP_STATE_I;
			slp_sync_q <= slp_meta_q;
			slp_prev_q <= slp_sync_q;
			// Two-bit code may skew in the synchroniser, so take it only after two equal samples
			if (slp_sync_q == slp_prev_q) begin
				slp_q <= slp_sync_q;
			end
		end
	end

	assign legacy = ~ctrl_q[CTRL_ACPI_MODE];
	assign btn_evt = evt.edge_evt[SRC_BUTTON];
	assign chipset_off = (slp_q == SLP_S5);
	// Chipset wake line is only edge sensitive, so the raw level never needs qualifying
	logic cs_wake_meta_q;
	logic cs_wake_sync_q;
	logic cs_wake_last_q;
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cs_wake_meta_q <= 1'b0;
			cs_wake_sync_q <= 1'b0;
			cs_wake_last_q <= 1'b0;
		end else begin
			cs_wake_meta_q <= CHIPSET_WAKE_I;
			cs_wake_sync_q <= cs_wake_meta_q;
			cs_wake_last_q <= cs_wake_sync_q;
		end
	end

	// Source qualification by mode and sleep depth
	always_comb begin
		logic s1;
		logic s4;
		logic grp;
		s1 = (slp_q == SLP_S1);
		s4 = (slp_q == SLP_S4) | (slp_q == SLP_S5);
		grp = 1'b0;
		if (legacy) begin
			grp = ctrl_q[CTRL_LEGACY_WAKE_EN] &
				(evt.edge_evt[SRC_RI_FIRST] | evt.edge_evt[SRC_PME] |
				(evt.edge_evt[SRC_RI_SECOND] & ~ctrl_q[CTRL_EMP_ON_B]) | evt.edge_evt[SRC_RTC]);
		end else begin
			grp = ((s1 | s4) & (evt.edge_evt[SRC_RI_FIRST] | evt.edge_evt[SRC_PME])) |
				((s1 | s4) & evt.edge_evt[SRC_RI_SECOND] & ~ctrl_q[CTRL_EMP_ON_B]) |
				(evt.edge_evt[SRC_RTC] & (s4 | (s1 & ctrl_q[CTRL_RTC_S1_EN]))) |
				(s1 & (evt.edge_evt[SRC_MOUSE] | evt.edge_evt[SRC_KBD] | evt.edge_evt[SRC_USB]));
		end
		wake_hit = grp | (cs_wake_sync_q & ~cs_wake_last_q);
	end

	// Power sequence
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_q <= ST_OFF;
			cnt_q <= 32'h0000_0000;
		end else begin
			case (state_q)
				ST_OFF: begin
					cnt_q <= 32'h0000_0000;
					if (btn_evt || wake_hit) begin
						state_q <= ST_SUPPLY_UP;
					end
				end
				ST_SUPPLY_UP: begin
					cnt_q <= cnt_q + 32'h0000_0001;
					if (cnt_q >= 32'(PWRGD_CYC - 1)) begin
						state_q <= ST_RESET;
						cnt_q <= 32'h0000_0000;
					end
				end
				ST_RESET: begin
					cnt_q <= cnt_q + 32'h0000_0001;
					if (cnt_q >= 32'(RESET_CYC - 1)) begin
						state_q <= ST_ON;
					end
				end
				ST_ON: begin
					if (chipset_off || force_off) begin
						state_q <= ST_OFF;
					end else if (slp_q != SLP_S0) begin
						state_q <= ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					if (chipset_off || force_off) begin
						state_q <= ST_OFF;
					end else if (slp_q == SLP_S0) begin
						state_q <= ST_ON;
					end
				end
				default: state_q <= ST_OFF;
			endcase
		end
	end

	// Registered so a multi-bit state change can never glitch the supply, power good or reset pins
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			supply_q <= 1'b0;
			pwr_good_q <= 1'b0;
			sys_reset_n_q <= 1'b0;
		end else begin
			supply_q <= (state_q != ST_OFF);
			pwr_good_q <= (state_q == ST_RESET) || (state_q == ST_ON) || (state_q == ST_SLEEP);
			sys_reset_n_q <= (state_q == ST_ON) || (state_q == ST_SLEEP);
		end
	end
	assign SUPPLY_ON_REQUEST_O = supply_q;
	assign PWR_GOOD_O = pwr_good_q;
	assign SYS_RESET_N_O = sys_reset_n_q;

	// Forced power-off safety timer for unserviced legacy SMI
	assign force_off = off_armed_q && (off_cnt_q >= 40'(FORCE_OFF_CYC - 1));
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			off_armed_q <= 1'b0;
			off_cnt_q <= 40'h00_0000_0000;
		end else if (chipset_off || state_q == ST_OFF || force_off) begin
			off_armed_q <= 1'b0;
			off_cnt_q <= 40'h00_0000_0000;
		end else if (btn_evt && legacy && state_q == ST_ON && !off_armed_q) begin
			off_armed_q <= 1'b1;
			off_cnt_q <= 40'h00_0000_0000;
		end else if (off_armed_q) begin
			off_cnt_q <= off_cnt_q + 40'h00_0000_0001;
		end
	end

	// Button forwarding, SMI, SCI and chipset wake pulses
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			btn_req_q <= 1'b0;
			smi_q <= 1'b0;
			sci_q <= 1'b0;
			wake_out_q <= 1'b0;
		end else begin
			btn_req_q <= evt.level[SRC_BUTTON];
			smi_q <= btn_evt && legacy && state_q == ST_ON;
			sci_q <= btn_evt && !legacy && (state_q == ST_ON || state_q == ST_SLEEP);
			wake_out_q <= btn_evt && !legacy && ctrl_q[CTRL_SLEEP_BUTTON] && state_q == ST_SLEEP;
		end
	end
	assign BUTTON_REQ_O = btn_req_q;
	assign SMI_O = smi_q;
	assign SCI_O = sci_q;
	assign CHIPSET_WAKE_O = wake_out_q;

	assign irq_set[IRQ_WAKE] = wake_hit && state_q == ST_OFF;
	assign irq_set[IRQ_BUTTON] = btn_evt;
	assign irq_set[IRQ_FORCED_OFF] = force_off;
	assign irq_set[IRQ_ON] = (state_q == ST_RESET) && (cnt_q >= 32'(RESET_CYC - 1));
	assign IRQ_O = |(irq_stat_q & irq_mask_q);

	// AXI4-Lite slave: write taken when address and data are both present
	logic wr_go;
	logic [7:0] wr_ofs;
	assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
	assign S_AXI_AWREADY = wr_go;
	assign S_AXI_WREADY = wr_go;
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign wr_ofs = S_AXI_AWADDR[7:0];
	assign irq_clr = (wr_go && S_AXI_AWADDR[31:8] == 24'h00_0000 && wr_ofs == IRQ_STAT_OFS && S_AXI_WSTRB[0]) ?
		S_AXI_WDATA[NUM_IRQ-1:0] : '0;

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ctrl_q <= CTRL_RESET;
			irq_mask_q <= '0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= 2'b00;
		end else begin
			if (wr_go) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= 2'b00;
				if (S_AXI_AWADDR[31:8] != 24'h00_0000) begin
					S_AXI_BRESP <= 2'b10;
				end else if (wr_ofs == CTRL_OFS) begin
					if (S_AXI_WSTRB[0]) begin
						ctrl_q[7:0] <= S_AXI_WDATA[7:0];
					end
				end else if (wr_ofs == IRQ_MASK_OFS) begin
					if (S_AXI_WSTRB[0]) begin
						irq_mask_q <= S_AXI_WDATA[NUM_IRQ-1:0];
					end
				end else if (wr_ofs != IRQ_STAT_OFS && wr_ofs != STAT_OFS) begin
					S_AXI_BRESP <= 2'b10;
				end
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// Set wins over a simultaneous write-one clear
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= 2'b00;
		end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RRESP <= 2'b00;
			S_AXI_RDATA <= 32'h0000_0000;
			if (S_AXI_ARADDR[31:8] != 24'h00_0000) begin
				S_AXI_RRESP <= 2'b10;
			end else if (S_AXI_ARADDR[7:0] == CTRL_OFS) begin
				S_AXI_RDATA <= ctrl_q;
			end else if (S_AXI_ARADDR[7:0] == STAT_OFS) begin
				S_AXI_RDATA <= {16'h0000, evt.level, 1'b0, state_q, slp_q, off_armed_q, SUPPLY_ON_REQUEST_O};
			end else if (S_AXI_ARADDR[7:0] == IRQ_STAT_OFS) begin
				S_AXI_RDATA <= {28'h000_0000, irq_stat_q};
			end else if (S_AXI_ARADDR[7:0] == IRQ_MASK_OFS) begin
				S_AXI_RDATA <= {28'h000_0000, irq_mask_q};
			end else begin
				S_AXI_RRESP <= 2'b10;
			end
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

endmodule

// *** verif/wpb_sequencer_assertions.sv ***
`timescale 1ns/100ps
module wpb_seq_checker #(
	parameter longint FORCE_OFF_CYC = 200
)(
	input wire logic SYS_CLK_I,
	input wire logic RST_N_I,
	input wire logic PWR_BUTTON_N_I,
	input wire logic [1:0] SLP_STATE_I,
	input wire logic SUPPLY_ON_REQUEST_O,
	input wire logic PWR_GOOD_O,
	input wire logic SYS_RESET_N_O,
	input wire logic BUTTON_REQ_O,
	input wire logic CHIPSET_WAKE_O,
	input wire logic SMI_O,
	input wire logic SCI_O
);
	default clocking @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	logic [2:0] up_q;
	longint wait_q;
	// Keeps reset contents of the sync flops out of the level check
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			up_q <= 3'h0;
			wait_q <= '0;
		end else begin
			if (up_q != 3'h7) up_q <= up_q + 3'h1;
			if (!SUPPLY_ON_REQUEST_O) wait_q <= '0;
			else if (SMI_O || wait_q != '0) wait_q <= wait_q + 1;
		end
	end
	a_pg_before_release: assert property ($rose(SYS_RESET_N_O) |-> PWR_GOOD_O && $past(PWR_GOOD_O, 4))
		else $error("reset released without power good");
	a_reset_after_pg: assert property ($rose(PWR_GOOD_O) |-> !SYS_RESET_N_O [*4])
		else $error("reset not held after power good");
	a_pg_needs_supply: assert property (PWR_GOOD_O |-> SUPPLY_ON_REQUEST_O)
		else $error("power good without supply");
	a_off_drops_supply: assert property (SYS_RESET_N_O && SLP_STATE_I == 2'h3 |-> ##[1:8] !SUPPLY_ON_REQUEST_O)
		else $error("supply kept after chipset off");
	a_button_forwarded: assert property (up_q == 3'h7 && $past(PWR_BUTTON_N_I, 2) == $past(PWR_BUTTON_N_I, 4)
		|-> BUTTON_REQ_O != $past(PWR_BUTTON_N_I, 3))
		else $error("button level not forwarded");
	a_smi_on_press: assert property (SMI_O |-> !$past(PWR_BUTTON_N_I, 2) && !SCI_O)
		else $error("smi without press");
	a_sci_on_press: assert property (SCI_O |-> !$past(PWR_BUTTON_N_I, 2))
		else $error("sci without press");
	a_wake_with_sci: assert property (CHIPSET_WAKE_O |-> SCI_O)
		else $error("chipset wake without sci");
	a_sci_keeps_power: assert property (SCI_O && SUPPLY_ON_REQUEST_O |=> SUPPLY_ON_REQUEST_O [*4])
		else $error("sci press removed power");
	a_press_powers_up: assert property ($fell(PWR_BUTTON_N_I) && !SUPPLY_ON_REQUEST_O
		|-> ##[2:8] SUPPLY_ON_REQUEST_O)
		else $error("press while off did not power up");
	a_forced_off_due: assert property (wait_q <= FORCE_OFF_CYC + 8)
		else $error("forced power off late");
	c_smi: cover property (SMI_O);
	c_wake: cover property (CHIPSET_WAKE_O);
	c_on: cover property ($rose(SYS_RESET_N_O));
endmodule
bind wpb_sequencer wpb_seq_checker #(.FORCE_OFF_CYC(FORCE_OFF_CYC)) wpb_seq_checker_inst (
	.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .PWR_BUTTON_N_I(PWR_BUTTON_N_I), .SLP_STATE_I(SLP_STATE_I),
	.SUPPLY_ON_REQUEST_O(SUPPLY_ON_REQUEST_O), .PWR_GOOD_O(PWR_GOOD_O), .SYS_RESET_N_O(SYS_RESET_N_O),
	.BUTTON_REQ_O(BUTTON_REQ_O), .CHIPSET_WAKE_O(CHIPSET_WAKE_O), .SMI_O(SMI_O), .SCI_O(SCI_O));

// *** verif/wpb_chipset_model.sv ***
`timescale 1ns/100ps
module wpb_chipset_model
	import wpb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic supply_on_i,
	input wire logic [1:0] target_i,
	input wire logic slow_i,
	output logic [1:0] slp_state_o
);
	logic [3:0] age_q;
	// Chipset settles a few cycles after the supply comes up; slow stretches it
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			age_q <= 4'h0;
			slp_state_o <= SLP_S5;
		end else if (!supply_on_i) begin
			age_q <= 4'h0;
			slp_state_o <= SLP_S5;
		end else begin
			if (age_q != 4'hF) age_q <= age_q + 4'h1;
			if (age_q >= (slow_i ? 4'h6 : 4'h2)) slp_state_o <= target_i;
		end
	end
endmodule

// *** verif/tb_wpb_sequencer.sv ***
`timescale 1ns/100ps
module tb_wpb_sequencer
	import wpb_pkg::*;
;
	typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e; logic [1:0] r;} wpb_row_t;
	logic clk = 0, rst_n = 0, btn_n = 1, slow = 0;
	logic [7:0] wk = '0, n_smi = '0, n_sci = '0, n_cw = '0, e_smi = '0, e_sci = '0, e_cw = '0;
	logic [1:0] tgt = SLP_S0, slp, bresp, rresp;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic sup, pg, rso, breq, cwo, smi, sci, irq, awr, wrdy, bv, arr, rv;
	int fails = 0, total_checks = 0;
	wpb_row_t rows [5] = '{'{CTRL_OFS, 32'h0000_0000, 32'h0000_0000, 2'h0},
		'{IRQ_MASK_OFS, 32'hFFFF_FFFF, 32'h0000_000F, 2'h0}, '{IRQ_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_0000, 2'h0},
		'{8'h10, 32'hFFFF_FFFF, 32'h0000_0000, 2'h2}, '{8'hFC, 32'h0000_0001, 32'h0000_0000, 2'h2}};
	wpb_sequencer #(.FORCE_OFF_CYC(200), .PWRGD_CYC(10), .RESET_CYC(5)) wpb_sequencer_inst (
		.SYS_CLK_I(clk), .RST_N_I(rst_n), .PWR_BUTTON_N_I(btn_n), .CHIPSET_WAKE_I(wk[7]),
		.RI_FIRST_SERIAL_PORT_I(wk[0]), .RI_SECOND_SERIAL_PORT_I(wk[1]), .PCI_PME_I(wk[2]),
		.RTC_ALARM_I(wk[3]), .MOUSE_WAKE_I(wk[4]), .KBD_WAKE_I(wk[5]), .USB_WAKE_I(wk[6]),
		.SLP_STATE_I(slp), .SUPPLY_ON_REQUEST_O(sup), .PWR_GOOD_O(pg), .SYS_RESET_N_O(rso),
		.BUTTON_REQ_O(breq), .CHIPSET_WAKE_O(cwo), .SMI_O(smi), .SCI_O(sci), .IRQ_O(irq),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
		.S_AXI_RREADY(rready));
	wpb_chipset_model wpb_chipset_model_inst (.clk_i(clk), .rst_n_i(rst_n), .supply_on_i(sup),
		.target_i(tgt), .slow_i(slow), .slp_state_o(slp));
	initial forever #4 clk = ~clk;
	always @(posedge clk) begin
		n_smi <= n_smi + {7'h00, smi === 1'b1};
		n_sci <= n_sci + {7'h00, sci === 1'b1};
		n_cw <= n_cw + {7'h00, cwo === 1'b1};
	end
	task close_out();
		$display("Checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk32(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("Error at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task chk1(input logic g, input logic e);
		chk32({31'h0000_0000, g}, {31'h0000_0000, e});
	endtask
	task chkcnt();
		chk32({8'h00, n_smi, n_sci, n_cw}, {8'h00, e_smi, e_sci, e_cw});
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clk);
		awaddr <= {24'h00_0000, a};
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do @(posedge clk); while (awr !== 1'b1);
		awv <= 1'b0;
		wv <= 1'b0;
		do @(posedge clk); while (bv !== 1'b1);
		bready <= 1'b0;
		chk32({30'h0000_0000, bresp}, {30'h0000_0000, r});
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge clk);
		araddr <= {24'h00_0000, a};
		arv <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge clk); while (rv !== 1'b1);
		rready <= 1'b0;
		chk32(rdata, e);
		chk32({30'h0000_0000, rresp}, {30'h0000_0000, r});
	endtask
	task press();
		btn_n <= 1'b0;
		repeat (10) @(posedge clk);
		chk1(breq, 1'b1);
		btn_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk1(breq, 1'b0);
	endtask
	// Source holds its line six cycles, then drops it and idles four, whether or not a wake followed
	task pulse(input int i);
		wk[i] <= 1'b1;
		repeat (6) @(posedge clk);
		wk[i] <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	initial begin
		repeat (8000) @(posedge clk);
		fails++;
		close_out();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			rd(rows[i].a, 32'h0000_0000, rows[i].r);
			wr(rows[i].a, rows[i].w, rows[i].r);
			rd(rows[i].a, rows[i].e, rows[i].r);
		end
		pulse(2);
		chk1(sup, 1'b0);
		wr(CTRL_OFS, 32'h0000_0001, 2'h0);
		pulse(2);
		chk1(sup, 1'b1);
		repeat (30) @(posedge clk);
		chk1(rso, 1'b1);
		rd(STAT_OFS, 32'h0000_0031, 2'h0);
		rd(IRQ_STAT_OFS, 32'h0000_0009, 2'h0);
		chk1(irq, 1'b1);
		wr(IRQ_STAT_OFS, 32'h0000_000F, 2'h0);
		rd(IRQ_STAT_OFS, 32'h0000_0000, 2'h0);
		chk1(irq, 1'b0);
		press();
		e_smi++;
		chkcnt();
		repeat (140) @(posedge clk);
		chk1(sup, 1'b1);
		repeat (100) @(posedge clk);
		chk1(sup, 1'b0);
		rd(IRQ_STAT_OFS, 32'h0000_0006, 2'h0);
		slow <= 1'b1;
		press();
		repeat (30) @(posedge clk);
		chk1(rso, 1'b1);
		wr(IRQ_STAT_OFS, 32'h0000_000F, 2'h0);
		press();
		e_smi++;
		tgt <= SLP_S5;
		repeat (10) @(posedge clk);
		chk1(sup, 1'b0);
		chkcnt();
		tgt <= SLP_S0;
		slow <= 1'b0;
		repeat (250) @(posedge clk);
		rd(IRQ_STAT_OFS, 32'h0000_0002, 2'h0);
		wr(CTRL_OFS, 32'h0000_0002, 2'h0);
		pulse(7);
		repeat (30) @(posedge clk);
		chk1(rso, 1'b1);
		press();
		e_sci++;
		chkcnt();
		repeat (250) @(posedge clk);
		chk1(sup, 1'b1);
		wr(CTRL_OFS, 32'h0000_0006, 2'h0);
		press();
		e_sci++;
		chkcnt();
		tgt <= SLP_S1;
		repeat (10) @(posedge clk);
		press();
		e_sci++;
		e_cw++;
		chkcnt();
		tgt <= SLP_S5;
		repeat (10) @(posedge clk);
		chk1(sup, 1'b0);
		tgt <= SLP_S0;
		wr(CTRL_OFS, 32'h0000_000A, 2'h0);
		wr(IRQ_MASK_OFS, 32'h0000_0000, 2'h0);
		wr(IRQ_STAT_OFS, 32'h0000_000F, 2'h0);
		pulse(1);
		chk1(sup, 1'b0);
		pulse(3);
		chk1(sup, 1'b1);
		chk1(irq, 1'b0);
		wr(IRQ_MASK_OFS, 32'h0000_0001, 2'h0);
		repeat (2) @(posedge clk);
		chk1(irq, 1'b1);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		chk32({28'h000_0000, sup, pg, rso, irq}, 32'h0000_0000);
		rst_n <= 1'b1;
		rd(CTRL_OFS, 32'h0000_0000, 2'h0);
		rd(STAT_OFS, 32'h0000_000C, 2'h0);
		rd(IRQ_STAT_OFS, 32'h0000_0000, 2'h0);
		wr(CTRL_OFS, 32'h0000_0001, 2'h0);
		pulse(0);
		chk1(sup, 1'b1);
		close_out();
	end
endmodule
